/* File: logic/cie_pkg.sv */
package cie_pkg;

  localparam int          CIE_N_SRC       = 8;
  localparam int          CIE_CNT_W       = 2;
  localparam int          CIE_COND_I_BIT  = 3;
  localparam logic [15:0] CIE_VEC_TOP     = 16'hFFFE;
  localparam logic [2:0]  CIE_FRAME_BYTES = 3'h5;
  localparam logic [2:0]  CIE_QUEUE_BYTES = 3'h3;
  localparam logic [2:0]  CIE_VEC_BYTES   = 3'h2;
  localparam logic [1:0]  CIE_PH_ISSUE    = 2'h0;
  localparam logic [1:0]  CIE_PH_CAPTURE  = 2'h2;
  localparam logic [2:0]  CIE_POP_COND    = 3'h0;
  localparam logic [2:0]  CIE_POP_A       = 3'h1;
  localparam logic [2:0]  CIE_POP_X       = 3'h2;
  localparam logic [2:0]  CIE_POP_PCH     = 3'h3;
  localparam logic [2:0]  CIE_POP_PC_LO   = 3'h4;

  typedef enum logic [2:0] {
    CIE_ST_IDLE  = 3'b000,
    CIE_ST_PUSH  = 3'b001,
    CIE_ST_VEC   = 3'b010,
    CIE_ST_FILL  = 3'b011,
    CIE_ST_POP   = 3'b100,
    CIE_ST_RFILL = 3'b101
  } cie_state_e;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  condition_code_reg;
  } cie_ctx_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cie_mem_s;

endpackage

/* File: logic/cie_src_slot.sv */
`timescale 1ns/100ps
`default_nettype none

module cie_src_slot
  import cie_pkg::*;
#(
  parameter int CNT_W = CIE_CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             src_event,
  input  wire logic             flag_clear,
  input  wire logic             flag_ack,
  output logic                  flag,
  output logic [CNT_W-1:0]      count
);

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // repeated events of one source queue up as a count, saturating at CNT_MAX
  wire              inc;
  wire              dec;
  wire [CNT_W-1:0]  next_count;

  assign inc        = src_event && (count != CNT_MAX);
  assign dec        = (flag_clear || flag_ack) && (count != '0) && !inc;
  // set beats clear: an event in the clearing cycle keeps the flag up
  assign next_count = inc && !(flag_clear || flag_ack) ? count + CNT_ONE :
                      inc && (count == '0)             ? CNT_ONE         :
                      dec                              ? count - CNT_ONE : count;
  assign flag       = (count != '0);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

`default_nettype wire

/* File: logic/cie_core_irq.sv */
`timescale 1ns/100ps
`default_nettype none

module cie_core_irq
  import cie_pkg::*;
#(
  parameter int          N_SRC   = CIE_N_SRC,
  parameter int          CNT_W   = CIE_CNT_W,
  parameter logic [15:0] VEC_TOP = CIE_VEC_TOP
) (
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  input  wire logic [N_SRC-1:0]          src_event,
  input  wire logic [N_SRC-1:0]          src_flag_clear,
  input  wire logic [N_SRC-1:0]          local_en,
  input  wire logic                      nest_en,
  input  wire logic                      sw_mask_wr,
  input  wire logic                      sw_mask_val,
  input  wire logic                      insn_done,
  input  wire logic                      return_from_interrupt,
  input  wire cie_ctx_s                  core_ctx,
  input  wire logic [15:0]               core_sp,
  input  wire logic [7:0]                mem_rdata,
  output cie_mem_s                       mem,
  output logic [N_SRC-1:0]               src_flag,
  output logic [N_SRC-1:0]               in_service,
  output logic                           i_mask,
  output logic                           core_hold,
  output logic                           ctx_load,
  output cie_ctx_s                       ctx_out,
  output logic [15:0]                    sp_out,
  output logic                           q_wr,
  output logic [7:0]                     q_byte
);

  localparam int SW = (N_SRC > 1) ? $clog2(N_SRC) : 1;

  cie_state_e        state;
  cie_state_e        next_state;
  logic [2:0]        cnt;
  logic [1:0]        ph;
  cie_ctx_s          ctx;
  logic [15:0]       sp_work;
  logic [15:0]       vec_pc;
  logic [SW-1:0]     src_sel;

  // sources
  wire [N_SRC-1:0]   ack_vec;
  wire [N_SRC-1:0]   qual;
  wire [N_SRC-1:0]   elig;
  wire [N_SRC-1:0]   run_above;
  wire [N_SRC:0]     run_seen;
  wire [N_SRC:0]     elig_seen;
  wire [N_SRC-1:0]   elig_first;
  wire [N_SRC-1:0]   svc_first;
  wire [N_SRC:0]     svc_seen;

  assign run_seen[0]  = 1'b0;
  assign elig_seen[0] = 1'b0;
  assign svc_seen[0]  = 1'b0;

  // index 0 is the most urgent; no two sources share a level
  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi = gi + 1) begin : g_src
      cie_src_slot #(
        .CNT_W      (CNT_W)
      ) u_slot (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .src_event  (src_event[gi]),
        .flag_clear (src_flag_clear[gi]),
        .flag_ack   (ack_vec[gi]),
        .flag       (src_flag[gi]),
        .count      ()
      );
      assign qual[gi]         = src_flag[gi] && local_en[gi];
      assign run_seen[gi+1]   = run_seen[gi] || in_service[gi];
      assign run_above[gi]    = !nest_en || !run_seen[gi+1];
      assign elig[gi]         = qual[gi] && run_above[gi];
      assign elig_first[gi]   = elig[gi] && !elig_seen[gi];
      assign elig_seen[gi+1]  = elig_seen[gi] || elig[gi];
      assign svc_first[gi]    = in_service[gi] && !svc_seen[gi];
      assign svc_seen[gi+1]   = svc_seen[gi] || in_service[gi];
    end
  endgenerate

  function automatic logic [SW-1:0] onehot_idx(input logic [N_SRC-1:0] oh);
    logic [SW-1:0] idx;
    idx = '0;
    for (int k = 0; k < N_SRC; k++) begin
      if (oh[k]) begin
        idx = SW'(k);
      end
    end
    return idx;
  endfunction

  wire            any_elig;
  wire [SW-1:0]   pick;
  wire            gate_open;
  wire            take;
  wire            do_return;

  assign any_elig  = elig_seen[N_SRC];
  assign pick      = onehot_idx(elig_first);
  // inside a nested handler the priority compare stands in for the mask
  assign gate_open = !i_mask || (nest_en && (in_service != '0));
  assign take      = (state == CIE_ST_IDLE) && insn_done && any_elig && gate_open;
  assign do_return = (state == CIE_ST_IDLE) && return_from_interrupt && !take;

  // sequencer
  wire            rd_state;
  wire            cap;
  wire            issue;
  wire [2:0]      last_cnt;
  wire            step_end;
  wire            vec_latch;
  wire [SW-1:0]   sel_now;
  wire [15:0]     vec_addr;
  wire [15:0]     rd_addr;
  wire [15:0]     wr_addr;
  wire [7:0]      wr_byte;
  wire            seq_done;

  assign rd_state  = (state == CIE_ST_VEC) || (state == CIE_ST_FILL) ||
                     (state == CIE_ST_POP) || (state == CIE_ST_RFILL);
  assign issue     = rd_state && (ph == CIE_PH_ISSUE);
  assign cap       = rd_state && (ph == CIE_PH_CAPTURE);
  assign last_cnt  = (state == CIE_ST_PUSH)  ? CIE_FRAME_BYTES - 3'h1 :
                     (state == CIE_ST_POP)   ? CIE_FRAME_BYTES - 3'h1 :
                     (state == CIE_ST_VEC)   ? CIE_VEC_BYTES - 3'h1   :
                                               CIE_QUEUE_BYTES - 3'h1;
  assign step_end  = (cnt == last_cnt) && ((state == CIE_ST_PUSH) || cap);

  // the source is chosen when the vector read goes out, after masking
  assign vec_latch = (state == CIE_ST_VEC) && issue && (cnt == 3'h0);
  assign sel_now   = (vec_latch && any_elig) ? pick : src_sel;
  assign vec_addr  = VEC_TOP - 16'(sel_now) * 16'h0002 - 16'h0002;
  assign ack_vec   = (vec_latch && any_elig && nest_en) ? elig_first : '0;

  assign rd_addr   = (state == CIE_ST_VEC)  ? vec_addr + 16'(cnt) :
                     (state == CIE_ST_FILL) ? vec_pc + 16'(cnt) :
                     (state == CIE_ST_POP)  ? sp_work + 16'h0001 + 16'(cnt) :
                                              ctx.pc + 16'(cnt);
  // stacking order: pc low, pc high, x, a, condition code, downward
  assign wr_addr   = sp_work - 16'(cnt);
  assign wr_byte   = (cnt == 3'h0) ? ctx.pc[7:0]  :
                     (cnt == 3'h1) ? ctx.pc[15:8] :
                     (cnt == 3'h2) ? ctx.x        :
                     (cnt == 3'h3) ? ctx.a        : ctx.condition_code_reg;

  assign seq_done  = step_end && ((state == CIE_ST_FILL) || (state == CIE_ST_RFILL));

  always_comb begin
    next_state = state;
    case (state)
      CIE_ST_IDLE: begin
        if (take) begin
          next_state = CIE_ST_PUSH;
        end else if (do_return) begin
          next_state = CIE_ST_POP;
        end
      end
      CIE_ST_PUSH: begin
        if (step_end) begin
          next_state = CIE_ST_VEC;
        end
      end
      CIE_ST_VEC: begin
        if (step_end) begin
          next_state = CIE_ST_FILL;
        end
      end
      CIE_ST_FILL: begin
        if (step_end) begin
          next_state = CIE_ST_IDLE;
        end
      end
      CIE_ST_POP: begin
        if (step_end) begin
          next_state = CIE_ST_RFILL;
        end
      end
      CIE_ST_RFILL: begin
        if (step_end) begin
          next_state = CIE_ST_IDLE;
        end
      end
      default: begin
        next_state = CIE_ST_IDLE;
      end
    endcase
  end

  // core is frozen for the whole frame, so it cannot race the stack
  assign core_hold = (state != CIE_ST_IDLE);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= CIE_ST_IDLE;
      cnt   <= 3'h0;
      ph    <= 2'h0;
    end else begin
      state <= next_state;
      if ((state == CIE_ST_IDLE) || step_end) begin
        cnt <= 3'h0;
        ph  <= 2'h0;
      end else if (state == CIE_ST_PUSH || cap) begin
        cnt <= cnt + 3'h1;
        ph  <= 2'h0;
      end else begin
        ph  <= ph + 2'h1;
      end
    end
  end

  // context
  wire [7:0]  cc_image;
  assign cc_image = {core_ctx.condition_code_reg[7:CIE_COND_I_BIT+1], i_mask,
                     core_ctx.condition_code_reg[CIE_COND_I_BIT-1:0]};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctx     <= '0;
      sp_work <= 16'h0000;
      vec_pc  <= 16'h0000;
      src_sel <= '0;
    end else begin
      if (take) begin
        ctx     <= '{pc: core_ctx.pc, x: core_ctx.x, a: core_ctx.a,
                     condition_code_reg: cc_image};
        sp_work <= core_sp;
        src_sel <= pick;
      end else if (do_return) begin
        sp_work <= core_sp;
      end
      if (state == CIE_ST_PUSH && step_end) begin
        sp_work <= sp_work - 16'(CIE_FRAME_BYTES);
      end
      if (state == CIE_ST_POP && step_end) begin
        sp_work <= sp_work + 16'(CIE_FRAME_BYTES);
      end
      if (vec_latch) begin
        src_sel <= sel_now;
      end
      if (cap && state == CIE_ST_VEC) begin
        if (cnt == 3'h0) begin
          vec_pc[15:8] <= mem_rdata;
        end else begin
          vec_pc[7:0]  <= mem_rdata;
        end
      end
      if (cap && state == CIE_ST_POP) begin
        case (cnt)
          CIE_POP_COND:  ctx.condition_code_reg <= mem_rdata;
          CIE_POP_A:     ctx.a                  <= mem_rdata;
          CIE_POP_X:     ctx.x                  <= mem_rdata;
          CIE_POP_PCH:   ctx.pc[15:8]           <= mem_rdata;
          CIE_POP_PC_LO: ctx.pc[7:0]            <= mem_rdata;
          default:       ctx.condition_code_reg <= ctx.condition_code_reg;
        endcase
      end
    end
  end

  // mask
  wire next_i_mask;
  // hardware updates outrank a software write in the same cycle
  assign next_i_mask = (state == CIE_ST_PUSH && step_end)                ? 1'b1 :
                       (cap && state == CIE_ST_POP && cnt == CIE_POP_COND) ?
                         mem_rdata[CIE_COND_I_BIT] :
                       (sw_mask_wr && state == CIE_ST_IDLE)               ? sw_mask_val :
                       i_mask;

  // nested bookkeeping: the lowest set bit is the handler now running
  wire [N_SRC-1:0] sel_oh;
  wire [N_SRC-1:0] next_in_service;
  assign sel_oh          = N_SRC'(1) << src_sel;
  assign next_in_service = (!nest_en)                                  ? '0 :
                           (state == CIE_ST_FILL && seq_done)          ? in_service | sel_oh :
                           (state == CIE_ST_RFILL && seq_done)         ? in_service & ~svc_first :
                           in_service;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      i_mask     <= 1'b1;
      in_service <= '0;
    end else begin
      i_mask     <= next_i_mask;
      in_service <= next_in_service;
    end
  end

  // outputs
  cie_mem_s next_mem;
  assign next_mem.addr  = (state == CIE_ST_PUSH) ? wr_addr : rd_addr;
  assign next_mem.wdata = (state == CIE_ST_PUSH) ? wr_byte : 8'h00;
  assign next_mem.wr    = (state == CIE_ST_PUSH);
  assign next_mem.rd    = issue;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem      <= '0;
      q_wr     <= 1'b0;
      q_byte   <= 8'h00;
      ctx_load <= 1'b0;
      ctx_out  <= '0;
      sp_out   <= 16'h0000;
    end else begin
      mem      <= next_mem;
      q_wr     <= cap && ((state == CIE_ST_FILL) || (state == CIE_ST_RFILL));
      q_byte   <= mem_rdata;
      ctx_load <= seq_done;
      if (seq_done && state == CIE_ST_FILL) begin
        ctx_out <= '{pc: vec_pc, x: ctx.x, a: ctx.a,
                     condition_code_reg: ctx.condition_code_reg | (8'h01 << CIE_COND_I_BIT)};
        sp_out  <= sp_work;
      end else if (seq_done) begin
        ctx_out <= ctx;
        sp_out  <= sp_work;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verification/cie_core_irq_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module cie_core_irq_chk
  import cie_pkg::*;
#(
  parameter int N_SRC = CIE_N_SRC
) (
  input wire logic             clk_sys,
  input wire logic             srst,
  input wire logic [N_SRC-1:0] src_event,
  input wire logic [N_SRC-1:0] local_en,
  input wire logic             nest_en,
  input wire logic             sw_mask_wr,
  input wire logic             insn_done,
  input wire logic             return_from_interrupt,
  input wire logic [15:0]      core_sp,
  input wire cie_mem_s         mem,
  input wire logic [N_SRC-1:0] src_flag,
  input wire logic [N_SRC-1:0] in_service,
  input wire logic             i_mask,
  input wire logic             core_hold,
  input wire logic             ctx_load,
  input wire cie_ctx_s         ctx_out,
  input wire logic [15:0]      sp_out,
  input wire logic             q_wr
);
  // sp and kind latched in every cycle a request is seen with core_hold low, so a late ctx_load still sees them
  logic [15:0] sp_q;
  logic        ret_q;
  logic [2:0]  qcnt;
  always_ff @(posedge clk_sys) begin
    if (!core_hold && (insn_done || return_from_interrupt)) begin
      sp_q  <= core_sp;
      ret_q <= return_from_interrupt;
    end
    qcnt <= (srst || ctx_load) ? 3'h0 : qcnt + {2'h0, q_wr};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_rst_mask; $fell(srst) |-> i_mask && !core_hold; endproperty
  property p_hold_cause; $rose(core_hold) |-> $past(insn_done || return_from_interrupt); endproperty
  property p_take_qual;
    $rose(core_hold) && $past(insn_done) |->
      $past(|(src_flag & local_en)) && $past(!i_mask || (nest_en && |in_service));
  endproperty
  property p_push_mask; $rose(core_hold) && $past(insn_done) |-> ##1 mem.wr [*5] ##[0:2] i_mask;
  endproperty
  property p_push_addr; mem.wr && $past(mem.wr) |-> mem.addr == $past(mem.addr) - 16'h0001;
  endproperty
  property p_sp; ctx_load |-> sp_out == (ret_q ? sp_q + 16'h0005 : sp_q - 16'h0005); endproperty
  property p_ret_mask;
    ctx_load && ret_q |-> i_mask == ctx_out.condition_code_reg[CIE_COND_I_BIT];
  endproperty
  property p_entry_mask;
    ctx_load && !ret_q |-> i_mask && ctx_out.condition_code_reg[CIE_COND_I_BIT];
  endproperty
  property p_qfill; ctx_load |-> qcnt + {2'h0, q_wr} == 3'h3; endproperty
  property p_flag_set; |src_event |=> (src_flag & $past(src_event)) == $past(src_event); endproperty
  property p_mask_idle;
    !core_hold && $past(!core_hold && !sw_mask_wr && !ctx_load) |-> $stable(i_mask);
  endproperty
  a_rst_mask: assert property (p_rst_mask) else $error("mask clear out of reset");
  a_hold_cause: assert property (p_hold_cause) else $error("hold without boundary");
  a_take_qual: assert property (p_take_qual) else $error("entry not qualified");
  a_push_mask: assert property (p_push_mask) else $error("push or mask order");
  a_push_addr: assert property (p_push_addr) else $error("stack not downward");
  a_sp: assert property (p_sp) else $error("stack pointer wrong");
  a_ret_mask: assert property (p_ret_mask) else $error("mask not restored");
  a_entry_mask: assert property (p_entry_mask) else $error("mask not set on entry");
  a_qfill: assert property (p_qfill) else $error("queue fill count");
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  a_mask_idle: assert property (p_mask_idle) else $error("mask changed idle");
  c_entry: cover property ($rose(core_hold) && $past(insn_done));
  c_return: cover property (ctx_load && ret_q);
  c_nested: cover property ($countones(in_service) == 2);
endmodule
bind cie_core_irq cie_core_irq_chk #(.N_SRC(N_SRC)) u_chk (.clk_sys(clk_sys), .srst(srst),
  .src_event(src_event), .local_en(local_en), .nest_en(nest_en), .sw_mask_wr(sw_mask_wr),
  .insn_done(insn_done), .return_from_interrupt(return_from_interrupt), .core_sp(core_sp),
  .mem(mem), .src_flag(src_flag), .in_service(in_service), .i_mask(i_mask),
  .core_hold(core_hold), .ctx_load(ctx_load), .ctx_out(ctx_out), .sp_out(sp_out), .q_wr(q_wr));
`default_nettype wire

/* File: verification/cie_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cie_mem_model
  import cie_pkg::*;
(
  input wire logic clk_sys,
  input wire cie_mem_s mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:65535];
  initial begin
    for (int a = 0; a < 65536; a++) m[a] = 8'(a) ^ 8'hA5;
    for (int i = 0; i < CIE_N_SRC; i++) begin
      m[16'(CIE_VEC_TOP - 2 * i - 2)] = 8'(8'h10 + i);
      m[16'(CIE_VEC_TOP - 2 * i - 1)] = 8'h00;
    end
    mem_rdata = 8'h00;
  end
  // no read: data lines toggle, so a stale sample never looks right
  always @(posedge clk_sys) begin
    if (mem.wr) m[mem.addr] <= mem.wdata;
    mem_rdata <= mem.rd ? m[mem.addr] : ~mem_rdata;
  end
endmodule
`default_nettype wire

/* File: verification/test_cie_core_irq.sv */
`timescale 1ns/100ps
`default_nettype none
module test_cie_core_irq;
  import cie_pkg::*;
  localparam cie_ctx_s CTX = '{16'h3456, 8'h77, 8'h55, 8'h60};
  localparam logic [15:0] SP0 = 16'h02FF;
  logic clk_sys = 0, srst = 1, nest_en = 0, sw_mask_wr = 0, sw_mask_val = 0;
  logic insn_done = 0, return_from_interrupt = 0;
  logic [7:0] src_event = 0, src_flag_clear = 0, local_en = 8'hDF, mem_rdata;
  logic [15:0] core_sp = SP0;
  cie_ctx_s core_ctx = CTX;
  cie_mem_s mem;
  cie_ctx_s ctx_out;
  logic [7:0] src_flag, in_service, q_byte;
  logic i_mask, core_hold, ctx_load, q_wr;
  logic [15:0] sp_out;
  logic [7:0] q_got [$];
  int err_count = 0, n_tests = 0;
  logic [39:0] fv;
  cie_core_irq dut (.clk_sys(clk_sys), .srst(srst), .src_event(src_event),
    .src_flag_clear(src_flag_clear), .local_en(local_en), .nest_en(nest_en),
    .sw_mask_wr(sw_mask_wr), .sw_mask_val(sw_mask_val), .insn_done(insn_done),
    .return_from_interrupt(return_from_interrupt), .core_ctx(core_ctx), .core_sp(core_sp),
    .mem_rdata(mem_rdata), .mem(mem), .src_flag(src_flag), .in_service(in_service),
    .i_mask(i_mask), .core_hold(core_hold), .ctx_load(ctx_load), .ctx_out(ctx_out),
    .sp_out(sp_out), .q_wr(q_wr), .q_byte(q_byte));
  cie_mem_model ram (.clk_sys(clk_sys), .mem(mem), .mem_rdata(mem_rdata));
  always #12.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (q_wr === 1'b1) q_got.push_back(q_byte);
  task chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task strobe(input logic [7:0] ev, input logic [7:0] cl, input logic d, input logic r,
              input logic mw);
    @(posedge clk_sys);
    {src_event, src_flag_clear, insn_done, return_from_interrupt, sw_mask_wr} <= {ev, cl, d, r, mw};
    @(posedge clk_sys);
    {src_event, src_flag_clear, insn_done, return_from_interrupt, sw_mask_wr} <= 19'h0;
  endtask
  task seq(input logic ret, input logic [15:0] sp);
    int n;
    n = 0;
    q_got.delete();
    @(posedge clk_sys) core_sp <= sp;
    strobe(8'h00, 8'h00, !ret, ret, 1'b0);
    while (ctx_load !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n < 60, 1, "no context load");
    repeat (2) @(negedge clk_sys);
  endtask
  task qchk(input logic [15:0] a);
    chk(q_got.size(), 3, "queue byte count");
    for (int k = 0; k < 3; k++) chk(q_got[k], 8'(a + k) ^ 8'hA5, "queue byte");
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #75000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 0;
    @(negedge clk_sys) chk(i_mask, 1, "mask after reset");
    strobe(8'h24, 8'h00, 1'b0, 1'b0, 1'b0);
    strobe(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    @(negedge clk_sys) chk(core_hold, 0, "entry while masked");
    chk(src_flag, 8'h24, "pending flags");
    $display("test masked done");
    strobe(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
    seq(1'b0, SP0);
    fv = {CTX.pc[7:0], CTX.pc[15:8], CTX.x, CTX.a, CTX.condition_code_reg};
    for (int k = 0; k < 5; k++) chk(ram.m[SP0 - 16'(k)], fv[39-8*k -: 8], "stack");
    chk(ctx_out.pc, 16'h1200, "vector of top source");
    chk(sp_out, SP0 - 16'h0005, "sp after entry");
    chk(i_mask, 1, "mask on entry");
    qchk(16'h1200);
    $display("test entry done");
    strobe(8'h00, 8'h04, 1'b0, 1'b0, 1'b0);
    strobe(8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
    @(negedge clk_sys) chk(i_mask, 0, "unmask inside handler");
    seq(1'b1, SP0 - 16'h0005);
    chk(ctx_out, CTX, "restored context");
    chk(i_mask, 0, "mask from image");
    chk(sp_out, SP0, "sp after return");
    qchk(CTX.pc);
    $display("test return done");
    strobe(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    @(negedge clk_sys) chk(core_hold, 0, "entry with local enable off");
    strobe(8'h00, 8'h20, 1'b0, 1'b0, 1'b0);
    @(negedge clk_sys) chk(src_flag, 8'h00, "flags cleared");
    $display("test local enable done");
    @(posedge clk_sys);
    nest_en <= 1;
    local_en <= 8'hFF;
    strobe(8'h10, 8'h00, 1'b0, 1'b0, 1'b0);
    seq(1'b0, SP0);
    chk(in_service, 8'h10, "one active level");
    chk(ctx_out.pc, 16'h1400, "vector four");
    strobe(8'h40, 8'h00, 1'b0, 1'b0, 1'b0);
    strobe(8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    @(negedge clk_sys) chk(core_hold, 0, "lower one must wait");
    strobe(8'h02, 8'h00, 1'b0, 1'b0, 1'b0);
    seq(1'b0, SP0 - 16'h0005);
    chk(ctx_out.pc, 16'h1100, "higher one preempts");
    chk(in_service, 8'h12, "two active levels");
    seq(1'b1, SP0 - 16'h000A);
    chk(in_service, 8'h10, "preempted resumes");
    chk(i_mask, 1, "mask kept in outer handler");
    chk(ctx_out.pc, CTX.pc, "resume address");
    seq(1'b1, SP0 - 16'h0005);
    chk(in_service, 8'h00, "all levels done");
    chk(i_mask, 0, "mask from outer image");
    seq(1'b0, SP0);
    chk(ctx_out.pc, 16'h1600, "pending lower served");
    $display("test nested done");
    stop_test;
  end
endmodule
`default_nettype wire
